// ==== design/sound_driven_led_control.sv ====
// Sound-driven LED control: configuration registers, AGC, colour mapping, ramps, routing
`timescale 1ns/1ps
module sound_driven_led_control #(
  parameter int PRECHARGE_CYCLES = sound_led_pkg::PRECHARGE_CYCLES,
  parameter int RAMP_STEP_CYCLES = sound_led_pkg::RAMP_STEP_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rd_data,
  input wire logic [9:0] sample_data,
  input wire logic sample_valid,
  output logic sound_active,
  output logic converter_continuous,
  output logic buffer_enable,
  output logic [2:0] buffer_gain,
  output sound_led_pkg::input_source_type buffer_source,
  output logic buffer_precharge,
  output sound_led_pkg::sink_drive_type [2:0] hv_sinks,
  output sound_led_pkg::sink_drive_type [2:0] colour_sinks,
  output sound_led_pkg::sink_drive_type [2:0] group_four_sinks,
  output sound_led_pkg::sink_drive_type [3:0] group_three_sinks
);
  logic [7:0] buf_ctrl;
  logic [7:0] gain_cfg;
  logic [7:0] out_cfg;
  logic [7:0] route_cfg;
  logic [7:0] ramp_cfg;

  // Register writes; reserved bits are never stored
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      buf_ctrl <= sound_led_pkg::RST_BUFFER_CTRL;
      gain_cfg <= sound_led_pkg::RST_GAIN_PRECHARGE;
      out_cfg <= sound_led_pkg::RST_OUTPUT_CFG;
      route_cfg <= sound_led_pkg::RST_SINK_ROUTE;
      ramp_cfg <= sound_led_pkg::RST_RAMP_INPUT;
    end else if (reg_wr_en) begin
      case (reg_addr)
        sound_led_pkg::ADDR_BUFFER_CTRL: buf_ctrl <= reg_wr_data & sound_led_pkg::MASK_BUFFER_CTRL;
        sound_led_pkg::ADDR_GAIN_PRECHARGE: gain_cfg <= reg_wr_data & sound_led_pkg::MASK_GAIN_PRECHARGE;
        sound_led_pkg::ADDR_OUTPUT_CFG: out_cfg <= reg_wr_data & sound_led_pkg::MASK_OUTPUT_CFG;
        sound_led_pkg::ADDR_SINK_ROUTE: route_cfg <= reg_wr_data & sound_led_pkg::MASK_SINK_ROUTE;
        sound_led_pkg::ADDR_RAMP_INPUT: ramp_cfg <= reg_wr_data & sound_led_pkg::MASK_RAMP_INPUT;
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rd_data <= 8'h00;
    end else if (reg_rd_en) begin
      case (reg_addr)
        sound_led_pkg::ADDR_BUFFER_CTRL: reg_rd_data <= buf_ctrl;
        sound_led_pkg::ADDR_GAIN_PRECHARGE: reg_rd_data <= gain_cfg;
        sound_led_pkg::ADDR_OUTPUT_CFG: reg_rd_data <= out_cfg;
        sound_led_pkg::ADDR_SINK_ROUTE: reg_rd_data <= route_cfg;
        sound_led_pkg::ADDR_RAMP_INPUT: reg_rd_data <= ramp_cfg;
        default: reg_rd_data <= 8'h00;
      endcase
    end
  end

  // Field views
  logic buf_on;
  logic man_precharge;
  logic precharge_dis;
  logic [2:0] colour_sel;
  logic [1:0] speed_down;
  logic [2:0] speed_up;
  logic [2:0] amp_code;
  sound_led_pkg::agc_mode_type agc_mode;
  logic any_enable;
  assign buf_on = buf_ctrl[sound_led_pkg::BUF_ON_BIT];
  assign colour_sel = buf_ctrl[sound_led_pkg::COLOUR_LSB +: 3];
  assign speed_down = buf_ctrl[sound_led_pkg::SPEED_DOWN_LSB +: 2];
  assign man_precharge = gain_cfg[sound_led_pkg::MAN_PRECHARGE_BIT];
  assign precharge_dis = gain_cfg[sound_led_pkg::PRECHARGE_DIS_BIT];
  assign agc_mode = sound_led_pkg::agc_mode_type'(gain_cfg[sound_led_pkg::AGC_LSB +: 3]);
  assign amp_code = out_cfg[sound_led_pkg::AMPLITUDE_LSB +: 3];
  assign speed_up = ramp_cfg[sound_led_pkg::SPEED_UP_LSB +: 3];
  assign any_enable = (|route_cfg) | out_cfg[sound_led_pkg::HV_EN_BIT]
    | out_cfg[sound_led_pkg::COLOUR_EN_BIT] | out_cfg[sound_led_pkg::GROUP_FOUR_EN_BIT];

  // Buffer control outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sound_active <= 1'b0;
      converter_continuous <= 1'b0;
      buffer_enable <= 1'b0;
      buffer_gain <= 3'h0;
      buffer_source <= sound_led_pkg::SRC_GROUP_THREE_SINK3;
    end else begin
      sound_active <= any_enable;
      // Converter is claimed whole; other conversions must wait
      converter_continuous <= any_enable;
      buffer_enable <= buf_on;
      buffer_gain <= gain_cfg[sound_led_pkg::GAIN_LSB +: 3];
      buffer_source <= sound_led_pkg::input_source_type'(ramp_cfg[sound_led_pkg::SOURCE_LSB +: 2]);
    end
  end

  // Precharge sequencer
  sound_led_pkg::precharge_state_type pre_state;
  sound_led_pkg::precharge_state_type next_pre_state;
  logic [15:0] pre_count;
  always_comb begin
    next_pre_state = pre_state;
    case (pre_state)
      sound_led_pkg::PRE_IDLE:
        if (buf_on) begin
          if (precharge_dis) next_pre_state = sound_led_pkg::PRE_DONE;
          else if (man_precharge) next_pre_state = sound_led_pkg::PRE_CONT;
          else next_pre_state = sound_led_pkg::PRE_AUTO;
        end
      sound_led_pkg::PRE_AUTO:
        if (!buf_on) next_pre_state = sound_led_pkg::PRE_IDLE;
        else if (precharge_dis) next_pre_state = sound_led_pkg::PRE_DONE;
        else if (man_precharge) next_pre_state = sound_led_pkg::PRE_CONT;
        else if (pre_count == 16'h0000) next_pre_state = sound_led_pkg::PRE_DONE;
      sound_led_pkg::PRE_CONT:
        if (!buf_on) next_pre_state = sound_led_pkg::PRE_IDLE;
        else if (precharge_dis || !man_precharge) next_pre_state = sound_led_pkg::PRE_DONE;
      sound_led_pkg::PRE_DONE:
        if (!buf_on) next_pre_state = sound_led_pkg::PRE_IDLE;
        else if (man_precharge && !precharge_dis) next_pre_state = sound_led_pkg::PRE_CONT;
      default: next_pre_state = sound_led_pkg::PRE_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pre_state <= sound_led_pkg::PRE_IDLE;
      pre_count <= 16'h0000;
      buffer_precharge <= 1'b0;
    end else begin
      pre_state <= next_pre_state;
      if (pre_state != sound_led_pkg::PRE_AUTO) pre_count <= 16'(PRECHARGE_CYCLES - 1);
      else if (pre_count != 16'h0000) pre_count <= pre_count - 16'h0001;
      buffer_precharge <= (next_pre_state == sound_led_pkg::PRE_AUTO)
        || (next_pre_state == sound_led_pkg::PRE_CONT);
    end
  end

  // Amplitude detection: fast attack, decay paced by samples
  logic [9:0] offset_mag;
  logic [7:0] amp;
  logic [7:0] peak;
  logic [5:0] decay_count;
  logic [5:0] decay_limit;
  assign offset_mag = (sample_data >= sound_led_pkg::MIDSCALE) ? sample_data - sound_led_pkg::MIDSCALE
    : sound_led_pkg::MIDSCALE - sample_data;
  assign amp = offset_mag[9] ? 8'hFF : offset_mag[8:1];
  // Odd codes decay fast, even codes slow
  assign decay_limit = agc_mode[0] ? sound_led_pkg::DECAY_FAST_SAMPLES
    : sound_led_pkg::DECAY_SLOW_SAMPLES;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      peak <= 8'h00;
      decay_count <= 6'h00;
    end else if (sample_valid) begin
      if (amp >= peak) begin
        peak <= amp;
        decay_count <= 6'h00;
      end else if (decay_count >= decay_limit) begin
        peak <= peak - 8'h01;
        decay_count <= 6'h00;
      end else begin
        decay_count <= decay_count + 6'h01;
      end
    end
  end

  // Gain in eighths from curve and detected level
  logic [3:0] level;
  logic [5:0] gain;
  logic [13:0] product;
  logic [7:0] comp;
  assign level = peak[7:4];
  always_comb begin
    case (agc_mode)
      sound_led_pkg::AGC_OFF: gain = 6'h08;
      sound_led_pkg::AGC_NOISE_GATE: gain = (amp < sound_led_pkg::NOISE_FLOOR) ? 6'h00 : 6'h08;
      sound_led_pkg::AGC_A_SLOW, sound_led_pkg::AGC_A_FAST:
        gain = (level == 4'h0) ? 6'h00 : 6'h10 - {3'h0, level[3:1]};
      sound_led_pkg::AGC_B_SLOW, sound_led_pkg::AGC_B_FAST:
        gain = (level == 4'h0) ? 6'h00 : 6'h18 - {2'h0, level};
      sound_led_pkg::AGC_C_SLOW, sound_led_pkg::AGC_C_FAST:
        gain = (level == 4'h0) ? 6'h00 : 6'h20 - {2'h0, level} - {3'h0, level[3:1]};
      default: gain = 6'h08;
    endcase
  end
  assign product = {6'h00, amp} * {8'h00, gain};

  // Compressed amplitude, saturated to eight bits
  always_ff @(posedge clk) begin
    if (sys_rst) comp <= 8'h00;
    else if (sample_valid) comp <= (product[13:11] != 3'h0) ? 8'hFF : product[10:3];
  end

  // Output amplitude in sixteenths
  logic [4:0] pct16;
  logic [12:0] scaled_full;
  logic [7:0] scaled;
  always_comb begin
    case (amp_code)
      3'h0: pct16 = 5'h01;
      3'h1: pct16 = 5'h02;
      3'h2: pct16 = 5'h04;
      3'h3: pct16 = 5'h08;
      3'h4: pct16 = 5'h0C;
      3'h5: pct16 = 5'h0E;
      3'h6: pct16 = 5'h0F;
      default: pct16 = 5'h10;
    endcase
  end
  assign scaled_full = {5'h00, comp} * {8'h00, pct16};
  assign scaled = (scaled_full[12]) ? 8'hFF : scaled_full[11:4];

  // Colour mask: bit 2 feeds channel one, bit 1 channel two, bit 0 channel three
  logic [2:0] colour_mask;
  logic [7:0] target [3];
  always_comb begin
    if (colour_sel != 3'h0) begin
      colour_mask = colour_sel;
    end else begin
      case (comp[7:5])
        3'h0: colour_mask = 3'b000;
        3'h1: colour_mask = 3'b001;
        3'h2: colour_mask = 3'b010;
        3'h3: colour_mask = 3'b011;
        3'h4: colour_mask = 3'b110;
        3'h5: colour_mask = 3'b100;
        default: colour_mask = 3'b111;
      endcase
    end
  end
  assign target[0] = colour_mask[2] ? scaled : 8'h00;
  assign target[1] = colour_mask[1] ? scaled : 8'h00;
  assign target[2] = colour_mask[0] ? scaled : 8'h00;

  // Ramp pacing: one step unit is a 255th of the ramp-unit time of a full-scale ramp
  logic [4:0] up_units;
  logic [4:0] down_units;
  logic [15:0] step_count;
  logic ramp_tick;
  always_comb begin
    case (speed_up)
      3'h0: up_units = 5'h00;
      3'h1: up_units = 5'h01;
      3'h2: up_units = 5'h02;
      3'h3: up_units = 5'h03;
      3'h4: up_units = 5'h04;
      3'h5: up_units = 5'h05;
      3'h6: up_units = 5'h08;
      default: up_units = 5'h10;
    endcase
    case (speed_down)
      2'h0: down_units = 5'h00;
      2'h1: down_units = 5'h04;
      2'h2: down_units = 5'h08;
      default: down_units = 5'h10;
    endcase
  end
  assign ramp_tick = (step_count == 16'(RAMP_STEP_CYCLES - 1));
  always_ff @(posedge clk) begin
    if (sys_rst || ramp_tick) step_count <= 16'h0000;
    else step_count <= step_count + 16'h0001;
  end

  logic [7:0] filtered [3];
  logic [4:0] unit_count [3];
  for (genvar ch = 0; ch < 3; ch++) begin : g_ramp
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        filtered[ch] <= 8'h00;
        unit_count[ch] <= 5'h00;
      end else if (filtered[ch] < target[ch]) begin
        if (up_units == 5'h00) begin
          filtered[ch] <= target[ch];
          unit_count[ch] <= 5'h00;
        end else if (ramp_tick) begin
          if (unit_count[ch] + 5'h01 >= up_units) begin
            filtered[ch] <= filtered[ch] + 8'h01;
            unit_count[ch] <= 5'h00;
          end else begin
            unit_count[ch] <= unit_count[ch] + 5'h01;
          end
        end
      end else if (filtered[ch] > target[ch]) begin
        if (down_units == 5'h00) begin
          filtered[ch] <= target[ch];
          unit_count[ch] <= 5'h00;
        end else if (ramp_tick) begin
          if (unit_count[ch] + 5'h01 >= down_units) begin
            filtered[ch] <= filtered[ch] - 8'h01;
            unit_count[ch] <= 5'h00;
          end else begin
            unit_count[ch] <= unit_count[ch] + 5'h01;
          end
        end
      end else begin
        unit_count[ch] <= 5'h00;
      end
    end
  end

  // Sink routing; fixed groups take channels one to three in order
  logic hv_en;
  logic colour_en;
  logic four_en;
  assign hv_en = out_cfg[sound_led_pkg::HV_EN_BIT];
  assign colour_en = out_cfg[sound_led_pkg::COLOUR_EN_BIT];
  assign four_en = out_cfg[sound_led_pkg::GROUP_FOUR_EN_BIT];
  // One process for the hv, colour and group-four outputs, one for group three, so no output has several writers
  always_ff @(posedge clk) begin
    for (int s = 0; s < 3; s++) begin
      if (sys_rst) begin
        hv_sinks[s] <= '0;
        colour_sinks[s] <= '0;
        group_four_sinks[s] <= '0;
      end else begin
        hv_sinks[s] <= {hv_en, hv_en ? filtered[s] : 8'h00};
        colour_sinks[s] <= {colour_en, colour_en ? filtered[s] : 8'h00};
        group_four_sinks[s] <= {four_en, four_en ? filtered[s] : 8'h00};
      end
    end
  end
  // Inactive sinks stay in their other modes; level shown as zero
  always_ff @(posedge clk) begin
    for (int g = 0; g < 4; g++) begin
      if (sys_rst) begin
        group_three_sinks[g] <= '0;
      end else begin
        case (sound_led_pkg::sink_route_type'(route_cfg[2 * g +: 2]))
          sound_led_pkg::ROUTE_CH_ONE: group_three_sinks[g] <= {1'b1, filtered[0]};
          sound_led_pkg::ROUTE_CH_TWO: group_three_sinks[g] <= {1'b1, filtered[1]};
          sound_led_pkg::ROUTE_CH_THREE: group_three_sinks[g] <= {1'b1, filtered[2]};
          default: group_three_sinks[g] <= {1'b0, 8'h00};
        endcase
      end
    end
  end

  a_precharge_disable: assert property (@(posedge clk) disable iff (sys_rst)
    precharge_dis |=> !buffer_precharge) else $error("precharge while disabled");
  a_precharge_manual: assert property (@(posedge clk) disable iff (sys_rst)
    buf_on && man_precharge && !precharge_dis |=> buffer_precharge) else $error("manual precharge missing");
  a_precharge_auto_start: assert property (@(posedge clk) disable iff (sys_rst)
    pre_state == sound_led_pkg::PRE_IDLE && buf_on && !man_precharge && !precharge_dis
    |=> buffer_precharge && pre_count == 16'(PRECHARGE_CYCLES - 1)) else $error("auto precharge not started");
  a_active_decode: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> sound_active == $past(any_enable)) else $error("active flag mismatch");
  a_converter_claim: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(any_enable) |=> converter_continuous ##1 converter_continuous || !$past(any_enable))
    else $error("converter not claimed");
  a_hv_off: assert property (@(posedge clk) disable iff (sys_rst)
    !hv_en |=> hv_sinks == '0) else $error("hv sinks driven while off");
  a_noise_gate: assert property (@(posedge clk) disable iff (sys_rst)
    agc_mode == sound_led_pkg::AGC_NOISE_GATE && sample_valid && amp < sound_led_pkg::NOISE_FLOOR
    |=> comp == 8'h00) else $error("noise not gated");
  a_full_amplitude: assert property (@(posedge clk) disable iff (sys_rst)
    amp_code == 3'h7 |-> scaled == comp) else $error("full amplitude not unity");
  a_single_red: assert property (@(posedge clk) disable iff (sys_rst)
    colour_sel == 3'b100 |-> target[1] == 8'h00 && target[2] == 8'h00) else $error("single colour leaks");
  a_sink1_ch3: assert property (@(posedge clk) disable iff (sys_rst)
    route_cfg[3:2] == 2'b11 |=> group_three_sinks[1] == {1'b1, $past(filtered[2])})
    else $error("sink1 route three wrong");
  a_rise_immediate: assert property (@(posedge clk) disable iff (sys_rst)
    up_units == 5'h00 && filtered[0] < target[0] |=> filtered[0] == $past(target[0]))
    else $error("immediate rise missing");
  a_fall_paced: assert property (@(posedge clk) disable iff (sys_rst)
    down_units != 5'h00 && filtered[0] > target[0] && !ramp_tick |=> filtered[0] == $past(filtered[0]))
    else $error("fall not paced");
endmodule

// ==== include/sound_led_pkg.sv ====
// Constants, field layout and types of the sound-driven LED control block
package sound_led_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_BUFFER_CTRL = 8'h46;
  localparam logic [7:0] ADDR_GAIN_PRECHARGE = 8'h47;
  localparam logic [7:0] ADDR_OUTPUT_CFG = 8'h48;
  localparam logic [7:0] ADDR_SINK_ROUTE = 8'h53;
  localparam logic [7:0] ADDR_RAMP_INPUT = 8'h55;
  // Reset values
  localparam logic [7:0] RST_BUFFER_CTRL = 8'h00;
  localparam logic [7:0] RST_GAIN_PRECHARGE = 8'h00;
  localparam logic [7:0] RST_OUTPUT_CFG = 8'h00;
  localparam logic [7:0] RST_SINK_ROUTE = 8'h00;
  localparam logic [7:0] RST_RAMP_INPUT = 8'h00;
  // Implemented bits; the rest read as zero
  localparam logic [7:0] MASK_BUFFER_CTRL = 8'hDD;
  localparam logic [7:0] MASK_GAIN_PRECHARGE = 8'hFF;
  localparam logic [7:0] MASK_OUTPUT_CFG = 8'h77;
  localparam logic [7:0] MASK_SINK_ROUTE = 8'hFF;
  localparam logic [7:0] MASK_RAMP_INPUT = 8'h3E;
  // Field positions
  localparam int BUF_ON_BIT = 0;
  localparam int COLOUR_LSB = 2;
  localparam int SPEED_DOWN_LSB = 6;
  localparam int GAIN_LSB = 0;
  localparam int AGC_LSB = 3;
  localparam int MAN_PRECHARGE_BIT = 6;
  localparam int PRECHARGE_DIS_BIT = 7;
  localparam int AMPLITUDE_LSB = 0;
  localparam int HV_EN_BIT = 4;
  localparam int COLOUR_EN_BIT = 5;
  localparam int GROUP_FOUR_EN_BIT = 6;
  localparam int SPEED_UP_LSB = 1;
  localparam int SOURCE_LSB = 4;
  // Timing
  localparam int CLK_FREQ_MHZ = 100;
  localparam int PRECHARGE_TIME_US = 300;
  localparam int PRECHARGE_CYCLES = PRECHARGE_TIME_US * CLK_FREQ_MHZ;
  localparam int RAMP_UNIT_MS = 50;
  localparam int FULL_SCALE = 255;
  localparam int RAMP_STEP_CYCLES = RAMP_UNIT_MS * 1000 * CLK_FREQ_MHZ / FULL_SCALE;
  localparam logic [5:0] DECAY_SLOW_SAMPLES = 6'h3F;
  localparam logic [5:0] DECAY_FAST_SAMPLES = 6'h07;
  localparam logic [7:0] NOISE_FLOOR = 8'h10;
  localparam logic [9:0] MIDSCALE = 10'h200;

  typedef enum logic [2:0] {
    AGC_OFF = 3'b000, AGC_NOISE_GATE = 3'b001, AGC_A_SLOW = 3'b010, AGC_A_FAST = 3'b011,
    AGC_B_SLOW = 3'b100, AGC_B_FAST = 3'b101, AGC_C_SLOW = 3'b110, AGC_C_FAST = 3'b111
  } agc_mode_type;
  typedef enum logic [1:0] {
    SRC_GROUP_THREE_SINK3 = 2'b00, SRC_BOOST_FEEDBACK_PIN = 2'b01,
    SRC_MULTIPURPOSE_PIN_ONE = 2'b10, SRC_MULTIPURPOSE_PIN_TWO = 2'b11
  } input_source_type;
  typedef enum logic [1:0] {
    ROUTE_OFF = 2'b00, ROUTE_CH_ONE = 2'b01, ROUTE_CH_TWO = 2'b10, ROUTE_CH_THREE = 2'b11
  } sink_route_type;
  typedef enum logic [1:0] {
    PRE_IDLE = 2'b00, PRE_AUTO = 2'b01, PRE_CONT = 2'b10, PRE_DONE = 2'b11
  } precharge_state_type;
  typedef struct packed {
    logic active;
    logic [7:0] level;
  } sink_drive_type;
endpackage

// ==== verif/sound_driven_led_control_tb_top.sv ====
// Self-checking testbench of the sound-driven LED control block
`timescale 1ns/1ps
module sound_driven_led_control_tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr_en = 1'b0;
  logic [7:0] reg_wr_data = 8'h00;
  logic reg_rd_en = 1'b0;
  logic [7:0] reg_rd_data;
  logic [9:0] sample_data = 10'h200;
  logic sample_valid = 1'b0;
  logic sound_active;
  logic converter_continuous;
  logic buffer_enable;
  logic [2:0] buffer_gain;
  sound_led_pkg::input_source_type buffer_source;
  logic buffer_precharge;
  sound_led_pkg::sink_drive_type [2:0] hv_sinks;
  sound_led_pkg::sink_drive_type [2:0] colour_sinks;
  sound_led_pkg::sink_drive_type [2:0] group_four_sinks;
  sound_led_pkg::sink_drive_type [3:0] group_three_sinks;
  int n_fail = 0;
  int checks_done = 0;
  int n;
  logic [7:0] d;
  // Address, write data, expected read-back; reserved bits read zero
  logic [23:0] rows [11] = '{24'h46_FFDD, 24'h47_FFFF, 24'h48_FF77, 24'h53_FFFF, 24'h55_FF3E, 24'h50_FF00,
    24'h46_0000, 24'h47_0000, 24'h48_0000, 24'h53_0000, 24'h55_0000};

  always #5 clk = ~clk;

  // Short counts keep precharge and ramps inside a brief run
  sound_driven_led_control #(.PRECHARGE_CYCLES(20), .RAMP_STEP_CYCLES(4)) sound_driven_led_control_inst (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .sample_data(sample_data), .sample_valid(sample_valid),
    .sound_active(sound_active), .converter_continuous(converter_continuous), .buffer_enable(buffer_enable),
    .buffer_gain(buffer_gain), .buffer_source(buffer_source), .buffer_precharge(buffer_precharge),
    .hv_sinks(hv_sinks), .colour_sinks(colour_sinks), .group_four_sinks(group_four_sinks),
    .group_three_sinks(group_three_sinks));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // Outputs follow a write two edges later
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr = a;
    reg_wr_data = v;
    reg_wr_en = 1'b1;
    cyc(1);
    reg_wr_en = 1'b0;
    cyc(2);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    reg_addr = a;
    reg_rd_en = 1'b1;
    cyc(1);
    reg_rd_en = 1'b0;
    v = reg_rd_data;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    cyc(5);
    sys_rst = 1'b0;
    chk(sound_active, 0);
    chk(buffer_precharge, 0);
    rd(8'h47, d);
    chk(d, 0);
    $display("reset test done");
    for (int i = 0; i < 11; i++) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], d);
      chk(d, rows[i][7:0]);
    end
    $display("register table test done");
    for (int b = 4; b < 7; b++) begin
      wr(8'h48, 8'(1 << b));
      chk({hv_sinks[2].active, colour_sinks[1].active, group_four_sinks[0].active}, 16'(4 >> (b - 4)));
      chk({sound_active, converter_continuous}, 2'b11);
    end
    wr(8'h48, 8'h07);
    chk(converter_continuous, 0);
    for (int v = 0; v < 4; v++) begin
      wr(8'h55, 8'(v << 4));
      chk(buffer_source, 16'(v));
    end
    $display("enable and source test done");
    // Loud input, single red colour, so only processed channel one carries light
    wr(8'h46, 8'h10);
    sample_data = 10'h3FF;
    sample_valid = 1'b1;
    for (int s = 0; s < 4; s++) begin
      for (int c = 0; c < 4; c++) begin
        wr(8'h53, 8'(c << (2 * s)));
        cyc(3);
        chk(group_three_sinks[s].active, c != 0);
        chk(group_three_sinks[s].level != 0, c == 1);
        chk(sound_active, c != 0);
      end
    end
    // Blue lights processed channel three only; half amplitude of full scale is 7F
    wr(8'h46, 8'h04);
    wr(8'h53, 8'h0C);
    wr(8'h48, 8'h73);
    chk(group_three_sinks[1].level, 8'h7F);
    chk(hv_sinks[2].level, 8'h7F);
    chk(colour_sinks[0].level, 0);
    chk(group_four_sinks[2].level, 8'h7F);
    wr(8'h46, 8'h10);
    wr(8'h48, 8'h07);
    $display("routing test done");
    wr(8'h53, 8'h01);
    for (int g = 1; g < 8; g++) begin
      wr(8'h47, 8'((g << 3) | g));
      chk(buffer_gain, 16'(g));
      cyc(20);
      chk(group_three_sinks[0].level != 0, 1);
    end
    // Small swing stays under the noise floor
    sample_data = 10'h208;
    wr(8'h47, 8'h08);
    cyc(6);
    chk(group_three_sinks[0].level, 0);
    $display("gain control test done");
    wr(8'h47, 8'h00);
    wr(8'h55, 8'h02);
    sample_data = 10'h3FF;
    cyc(12);
    chk(group_three_sinks[0].level > 0 && group_three_sinks[0].level < 8, 1);
    sample_data = 10'h200;
    cyc(6);
    chk(group_three_sinks[0].level, 0);
    sample_valid = 1'b0;
    $display("ramp test done");
    wr(8'h46, 8'h00);
    wr(8'h46, 8'h01);
    chk(buffer_enable, 1);
    n = 0;
    while (buffer_precharge === 1'b1 && n < 100) begin
      n++;
      cyc(1);
    end
    if (n >= 100) begin
      n_fail++;
      end_sim();
    end
    // Precharge rose one cycle before the write task returned
    chk(n + 1, 20);
    wr(8'h46, 8'h00);
    wr(8'h47, 8'h80);
    wr(8'h46, 8'h01);
    n = 0;
    repeat (25) begin
      n += int'(buffer_precharge);
      cyc(1);
    end
    chk(n, 0);
    wr(8'h46, 8'h00);
    wr(8'h47, 8'h40);
    wr(8'h46, 8'h01);
    cyc(40);
    chk(buffer_precharge, 1);
    wr(8'h46, 8'h00);
    chk(buffer_precharge, 0);
    chk(buffer_enable, 0);
    $display("precharge test done");
    // Reset in mid-run with fields set
    wr(8'h48, 8'h10);
    sys_rst = 1'b1;
    cyc(2);
    sys_rst = 1'b0;
    rd(8'h48, d);
    chk(d, 0);
    chk(sound_active, 0);
    $display("second reset test done");
    end_sim();
  end
endmodule
